// ==== cxd_regs.vh ====
// Constants for the transfer, test, trap and wait execution slice
`ifndef CXD_REGS_VH
`define CXD_REGS_VH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define CXD_OP_TRAP     8'h83
`define CXD_OP_A2F      8'h84
`define CXD_OP_F2A      8'h85
`define CXD_OP_A2X      8'h97
`define CXD_OP_X2A      8'h9f
`define CXD_OP_SP2X     8'h95
`define CXD_OP_X2SP     8'h94
`define CXD_OP_WAIT     8'h8f
`define CXD_OP_TST_DIR  8'h3d
`define CXD_OP_TST_A    8'h4d
`define CXD_OP_TST_X    8'h5d
`define CXD_OP_TST_IX1  8'h6d
`define CXD_OP_TST_IX   8'h7d
`define CXD_OP_PREFIX   8'h9e
`define CXD_OP_TST_SP1  8'h6d
// ----------------------------------------
// Cycle counts
// ----------------------------------------
`define CXD_CYC_TRAP    4'd9
`define CXD_CYC_A2F     4'd2
`define CXD_CYC_ONE     4'd1
`define CXD_CYC_SPX     4'd2
`define CXD_CYC_TST_DIR 4'd3
`define CXD_CYC_TST_IX1 4'd3
`define CXD_CYC_TST_IX  4'd2
`define CXD_CYC_TST_SP1 4'd4
// ----------------------------------------
// Flag positions, reset values, fixed flag bits and vector addresses
// ----------------------------------------
`define CXD_F_V         7
`define CXD_F_H         4
`define CXD_F_I         3
`define CXD_F_N         2
`define CXD_F_Z         1
`define CXD_F_C         0
`define CXD_FLAGS_RST   8'h68
`define CXD_FLAGS_FIX   8'h60
`define CXD_SP_RST      16'h00ff
`define CXD_VEC_HI      16'hfffc
`define CXD_VEC_LO      16'hfffd
`endif

// ==== cxd_test_alu.v ====
// Test-for-sign-or-zero flag computation
`timescale 1ns/1ps
module cxd_test_alu (
  input  wire [7:0] operand_i,
  input  wire [7:0] flags_i,
  output wire [7:0] flags_o
);
  // ----------------------------------------
  // Operand minus zero: V cleared, N and Z from value
  // ----------------------------------------
  assign flags_o = {1'b0, flags_i[6:3], operand_i[7], (operand_i == 8'h00), flags_i[0]};
endmodule // cxd_test_alu

// ==== cxd_exec.v ====
// Execution core for transfer, test, trap and wait instructions
// Operation
// - Trap advances PC, pushes PROGRAM_COUNTER_LOW, PROGRAM_COUNTER_HIGH, X, A, flags; SP decrements; 9 cycles.
// - After trap stacking set interrupt mask; other flags kept.
// - Trap loads PC high from vector high, then low from vector low.
// - Acc-to-flags copies accumulator to all six flags in 2 cycles.
// - Acc-to-index copies accumulator to index low, flags kept, 1 cycle.
// - Flags-to-acc copies flags into accumulator, flags kept, 1 cycle.
// - Test subtracts zero, clears V, sets N and Z from the value, keeps others.
// - Test opcodes 3D,4D,5D,6D,7D,9E6D with 3,1,1,3,2,4 cycles.
// - SP-to-index loads H:X with SP plus one in 2 cycles.
// - Index-to-acc copies index low into accumulator, 1 cycle.
// - Index-to-SP loads SP with H:X minus one in 2 cycles.
// - Wait clears interrupt mask then halts until interrupt; 1 cycle.
`timescale 1ns/1ps
`include "cxd_regs.vh"
module cxd_exec (
  input  wire        clock_i,
  input  wire        rstn_i,
  input  wire        op_valid_i,
  input  wire [7:0]  op_i,
  input  wire [7:0]  op2_i,
  input  wire [7:0]  operand_i,
  input  wire [7:0]  mem_rdata_i,
  input  wire        irq_i,
  output reg         op_ready_o,
  output reg         mem_we_o,
  output reg         mem_re_o,
  output reg  [15:0] mem_addr_o,
  output reg  [7:0]  mem_wdata_o,
  output reg  [15:0] pc_o,
  output reg  [7:0]  acc_o,
  output reg  [7:0]  idx_hi_o,
  output reg  [7:0]  idx_lo_o,
  output reg  [15:0] sp_o,
  output reg  [7:0]  flags_o,
  output reg         halted_o
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE  = 3'd0;
  localparam ST_BUSY  = 3'd1;
  localparam ST_PUSH  = 3'd2;
  localparam ST_VECH  = 3'd3;
  localparam ST_VECL  = 3'd4;
  localparam ST_WAIT  = 3'd5;
  localparam ST_VREQ  = 3'd6;

  reg  [2:0] state;
  reg  [3:0] cnt;
  reg  [2:0] push_idx;
  reg  [7:0] pend_flags;
  reg        irq_s1;
  reg        irq_s2;
  wire [7:0] tst_acc_flags;
  wire [7:0] tst_x_flags;
  wire [7:0] tst_mem_flags;

  // Cycle count for a decoded opcode, zero when not in this slice
  function [3:0] cyc_of;
    input [7:0] op;
    input [7:0] op2;
    begin
      case (op)
        `CXD_OP_TRAP:    cyc_of = `CXD_CYC_TRAP;
        `CXD_OP_A2F:     cyc_of = `CXD_CYC_A2F;
        `CXD_OP_F2A:     cyc_of = `CXD_CYC_ONE;
        `CXD_OP_A2X:     cyc_of = `CXD_CYC_ONE;
        `CXD_OP_X2A:     cyc_of = `CXD_CYC_ONE;
        `CXD_OP_SP2X:    cyc_of = `CXD_CYC_SPX;
        `CXD_OP_X2SP:    cyc_of = `CXD_CYC_SPX;
        `CXD_OP_WAIT:    cyc_of = `CXD_CYC_ONE;
        `CXD_OP_TST_DIR: cyc_of = `CXD_CYC_TST_DIR;
        `CXD_OP_TST_A:   cyc_of = `CXD_CYC_ONE;
        `CXD_OP_TST_X:   cyc_of = `CXD_CYC_ONE;
        `CXD_OP_TST_IX1: cyc_of = `CXD_CYC_TST_IX1;
        `CXD_OP_TST_IX:  cyc_of = `CXD_CYC_TST_IX;
        `CXD_OP_PREFIX:  cyc_of = (op2 == `CXD_OP_TST_SP1) ? `CXD_CYC_TST_SP1 : 4'd0;
        default:         cyc_of = 4'd0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Test flag units
  // ----------------------------------------
  cxd_test_alu u_tst_a (
    .operand_i (acc_o),
    .flags_i   (flags_o),
    .flags_o   (tst_acc_flags)
  );
  cxd_test_alu u_tst_x (
    .operand_i (idx_lo_o),
    .flags_i   (flags_o),
    .flags_o   (tst_x_flags)
  );
  cxd_test_alu u_tst_m (
    .operand_i (operand_i),
    .flags_i   (flags_o),
    .flags_o   (tst_mem_flags)
  );

  // Interrupt request synchroniser
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_s1 <= 1'b0;
      irq_s2 <= 1'b0;
    end else begin
      irq_s1 <= irq_i;
      irq_s2 <= irq_s1;
    end
  end

  // ----------------------------------------
  // Main sequencer
  // ----------------------------------------
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state       <= ST_IDLE;
      cnt         <= 4'd0;
      push_idx    <= 3'd0;
      pend_flags  <= 8'h00;
      op_ready_o  <= 1'b1;
      mem_we_o    <= 1'b0;
      mem_re_o    <= 1'b0;
      mem_addr_o  <= 16'h0000;
      mem_wdata_o <= 8'h00;
      pc_o        <= 16'h0000;
      acc_o       <= 8'h00;
      idx_hi_o    <= 8'h00;
      idx_lo_o    <= 8'h00;
      sp_o        <= `CXD_SP_RST;
      flags_o     <= `CXD_FLAGS_RST;
      halted_o    <= 1'b0;
    end else begin
      mem_we_o <= 1'b0;
      mem_re_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (op_valid_i && cyc_of(op_i, op2_i) != 4'd0) begin
            op_ready_o <= 1'b0;
            cnt        <= cyc_of(op_i, op2_i) - 4'd1;
            state      <= ST_BUSY;
            case (op_i)
              `CXD_OP_TRAP: begin
                pc_o     <= pc_o + 16'h0001;
                push_idx <= 3'd0;
                state    <= ST_PUSH;
              end
              `CXD_OP_A2F:  pend_flags <= acc_o | `CXD_FLAGS_FIX;
              `CXD_OP_F2A:  acc_o <= flags_o;
              `CXD_OP_A2X:  idx_lo_o <= acc_o;
              `CXD_OP_X2A:  acc_o <= idx_lo_o;
              `CXD_OP_SP2X: {idx_hi_o, idx_lo_o} <= sp_o + 16'h0001;
              `CXD_OP_X2SP: sp_o <= {idx_hi_o, idx_lo_o} - 16'h0001;
              `CXD_OP_WAIT: begin
                flags_o[`CXD_F_I] <= 1'b0;
                halted_o          <= 1'b1;
                state             <= ST_WAIT;
              end
              `CXD_OP_TST_A: flags_o <= tst_acc_flags;
              `CXD_OP_TST_X: flags_o <= tst_x_flags;
              default:       pend_flags <= tst_mem_flags;
            endcase
            if (cyc_of(op_i, op2_i) == `CXD_CYC_ONE && op_i != `CXD_OP_WAIT) begin
              op_ready_o <= 1'b1;
              state      <= ST_IDLE;
            end
          end
        end
        ST_BUSY: begin
          cnt <= cnt - 4'd1;
          if (cnt == 4'd1) begin
            // Flag updates of multi-cycle ops other than trap land on the final cycle
            if (op_i == `CXD_OP_A2F || op_i == `CXD_OP_PREFIX || op_i[3:0] == 4'hd)
              flags_o <= pend_flags;
            op_ready_o <= 1'b1;
            state      <= ST_IDLE;
          end
        end
        ST_PUSH: begin
          cnt         <= cnt - 4'd1;
          mem_we_o    <= 1'b1;
          mem_addr_o  <= sp_o;
          sp_o        <= sp_o - 16'h0001;
          push_idx    <= push_idx + 3'd1;
          case (push_idx)
            3'd0:    mem_wdata_o <= pc_o[7:0];
            3'd1:    mem_wdata_o <= pc_o[15:8];
            3'd2:    mem_wdata_o <= idx_lo_o;
            3'd3:    mem_wdata_o <= acc_o;
            default: mem_wdata_o <= flags_o;
          endcase
          if (push_idx == 3'd4) begin
            flags_o[`CXD_F_I] <= 1'b1;
            state             <= ST_VREQ;
          end
        end
        // Vector read starts a cycle after the last push so no write shares the address
        ST_VREQ: begin
          cnt        <= cnt - 4'd1;
          mem_re_o   <= 1'b1;
          mem_addr_o <= `CXD_VEC_HI;
          state      <= ST_VECH;
        end
        ST_VECH: begin
          cnt        <= cnt - 4'd1;
          pc_o[15:8] <= mem_rdata_i;
          mem_re_o   <= 1'b1;
          mem_addr_o <= `CXD_VEC_LO;
          state      <= ST_VECL;
        end
        ST_VECL: begin
          cnt       <= cnt - 4'd1;
          pc_o[7:0] <= mem_rdata_i;
          state     <= ST_BUSY;
          if (cnt <= 4'd1) begin
            op_ready_o <= 1'b1;
            state      <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          // Sequencer idles with halted_o set; a synchronised interrupt with the mask clear restarts into trap stacking
          if (irq_s2 && !flags_o[`CXD_F_I]) begin
            halted_o <= 1'b0;
            pc_o     <= pc_o + 16'h0001;
            push_idx <= 3'd0;
            cnt      <= `CXD_CYC_TRAP - 4'd1;
            state    <= ST_PUSH;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // cxd_exec

// ==== cxd_mem_model.sv ====
// Behavioural system memory holding the stack and the trap vectors
`timescale 1ns/1ps
`include "cxd_regs.vh"
module cxd_mem_model #(parameter [15:0] VEC = 16'h1234) (
  input  wire        clock_i,
  input  wire        we_i,
  input  wire        re_i,
  input  wire [15:0] addr_i,
  input  wire [7:0]  wdata_i,
  output wire [7:0]  rdata_o
);
  reg [7:0] mem [0:65535];
  reg [7:0] last;
  // Vector bytes are arbitrary test values
  initial begin
    mem[`CXD_VEC_HI] = VEC[15:8];
    mem[`CXD_VEC_LO] = VEC[7:0];
    last = 8'h00;
  end
  // Writes land at the edge; the last byte read is kept for the idle line
  always @(posedge clock_i) begin
    if (we_i) mem[addr_i] <= wdata_i;
    if (re_i) last <= mem[addr_i];
  end
  // Read data stands while re_i is high; idle line shows the inverse, never stale data
  assign rdata_o = re_i ? mem[addr_i] : ~last;
endmodule // cxd_mem_model

// ==== cxd_exec_assertions.sv ====
// Port-level assertions for the execution slice
`timescale 1ns/1ps
`include "cxd_regs.vh"
module cxd_exec_chk (
  input wire        clock_i,
  input wire        rstn_i,
  input wire        op_valid_i,
  input wire [7:0]  op_i,
  input wire        op_ready_o,
  input wire        mem_we_o,
  input wire        mem_re_o,
  input wire [15:0] mem_addr_o,
  input wire [7:0]  acc_o,
  input wire [7:0]  idx_lo_o,
  input wire [7:0]  flags_o,
  input wire        halted_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Opcode accepted at this edge
  wire take = op_ready_o && op_valid_i;
  property p_push; $rose(mem_we_o) |-> mem_we_o [*5] ##1 !mem_we_o; endproperty
  a_push: assert property (p_push) else $error("push burst length wrong");
  property p_trap; take && op_i == `CXD_OP_TRAP |=> !op_ready_o [*8] ##1 op_ready_o; endproperty
  a_trap: assert property (p_trap) else $error("trap length wrong");
  property p_a2f; take && op_i == `CXD_OP_A2F |=> !op_ready_o ##1
    (op_ready_o && flags_o == ($past(acc_o, 2) | `CXD_FLAGS_FIX)); endproperty
  a_a2f: assert property (p_a2f) else $error("acc to flags wrong");
  property p_tst; take && op_i == `CXD_OP_TST_X |=> flags_o == (($past(flags_o) & 8'h79) |
    {5'h00, $past(idx_lo_o[7]), $past(idx_lo_o) == 8'h00, 1'b0}); endproperty
  a_tst: assert property (p_tst) else $error("test flags wrong");
  property p_vec; $rose(mem_re_o) |-> mem_addr_o == `CXD_VEC_HI ##1
    (mem_re_o && mem_addr_o == `CXD_VEC_LO); endproperty
  a_vec: assert property (p_vec) else $error("vector fetch order wrong");
  property p_mask; $rose(mem_re_o) |-> ##2 flags_o[`CXD_F_I]; endproperty
  a_mask: assert property (p_mask) else $error("mask not set");
  property p_halt; $rose(halted_o) |-> !flags_o[`CXD_F_I]; endproperty
  a_halt: assert property (p_halt) else $error("mask not cleared in wait");
  property p_wake; $fell(halted_o) |-> ##[0:4] mem_we_o; endproperty
  a_wake: assert property (p_wake) else $error("no stacking after wake");
endmodule // cxd_exec_chk
bind cxd_exec cxd_exec_chk u_chk (.clock_i(clock_i), .rstn_i(rstn_i), .op_valid_i(op_valid_i),
  .op_i(op_i), .op_ready_o(op_ready_o), .mem_we_o(mem_we_o), .mem_re_o(mem_re_o),
  .mem_addr_o(mem_addr_o), .acc_o(acc_o), .idx_lo_o(idx_lo_o), .flags_o(flags_o),
  .halted_o(halted_o));

// ==== test_cpu_transfer_test_swi_wait_exec.sv ====
// Random instruction bench for the execution slice
`timescale 1ns/1ps
`include "cxd_regs.vh"
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", nm, e, s); end end
module test_cpu_transfer_test_swi_wait_exec;
  localparam [15:0] VEC = 16'h1234;
  reg         clock_i = 0, rstn_i = 0, op_valid_i = 0, irq_i = 0;
  reg  [7:0]  op_i = 8'h00, op2_i = `CXD_OP_TST_SP1, operand_i = 8'h00;
  wire        op_ready_o, mem_we_o, mem_re_o, halted_o;
  wire [15:0] mem_addr_o, pc_o, sp_o;
  wire [7:0]  mem_wdata_o, mem_rdata_i, acc_o, idx_hi_o, idx_lo_o, flags_o;
  reg  [31:0] st = 32'd79943;
  reg  [7:0]  acc = 8'h00, x = 8'h00, h = 8'h00, fl = `CXD_FLAGS_RST, v;
  reg  [15:0] sp = `CXD_SP_RST, pc = 16'h0000, p;
  integer     fails = 0, n_checks = 0, n, i;
  reg  [7:0]  ops [0:12] = '{`CXD_OP_TRAP, `CXD_OP_A2F, `CXD_OP_A2X, `CXD_OP_F2A, `CXD_OP_X2A,
    `CXD_OP_SP2X, `CXD_OP_X2SP, `CXD_OP_TST_DIR, `CXD_OP_TST_A, `CXD_OP_TST_X,
    `CXD_OP_TST_IX1, `CXD_OP_TST_IX, `CXD_OP_PREFIX};
  integer     cyc [0:12] = '{9, 2, 1, 1, 1, 2, 2, 3, 1, 1, 3, 2, 4};
  cxd_exec DUT (.clock_i(clock_i), .rstn_i(rstn_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .op2_i(op2_i), .operand_i(operand_i), .mem_rdata_i(mem_rdata_i), .irq_i(irq_i),
    .op_ready_o(op_ready_o), .mem_we_o(mem_we_o), .mem_re_o(mem_re_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .pc_o(pc_o), .acc_o(acc_o), .idx_hi_o(idx_hi_o),
    .idx_lo_o(idx_lo_o), .sp_o(sp_o), .flags_o(flags_o), .halted_o(halted_o));
  cxd_mem_model #(.VEC(VEC)) u_mem (.clock_i(clock_i), .we_i(mem_we_o), .re_i(mem_re_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
  // Clock at 200 MHz
  initial forever #2.5 clock_i = ~clock_i;
  function [31:0] rnd;
    begin
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      rnd = st;
    end
  endfunction
  function [7:0] m(input [15:0] d);
    m = u_mem.mem[sp - d];
  endfunction
  task end_sim;
    begin
      if (fails == 0 && n_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task tick;
    begin
      @(posedge clock_i);
      #1;
    end
  endtask
  // Bounded wait: ready high (sel 0) or halted low (sel 1)
  task await(input integer sel);
    begin
      n = 1;
      while ((sel ? halted_o !== 1'b0 : op_ready_o !== 1'b1) && n < 40) begin
        tick;
        n++;
      end
      if (n >= 40) begin
        fails++;
        end_sim;
      end
    end
  endtask
  task cmp;
    begin
      `CHK("acc", acc, acc_o)
      `CHK("index", {h, x}, {idx_hi_o, idx_lo_o})
      `CHK("sp", sp, sp_o)
      `CHK("flags", fl, flags_o)
    end
  endtask
  // Issue one table opcode, time it and update the reference model
  task run(input integer k);
    begin
      // Keep the stack well clear of the vector bytes
      if (k == 6 && {h, x} < 16'h0060) k = 5;
      tick;
      op_i = ops[k];
      operand_i = rnd();
      op_valid_i = 1;
      tick;
      op_valid_i = 0;
      await(0);
      `CHK("cycles", cyc[k], n)
      v = (k == 8) ? acc : (k == 9) ? x : operand_i;
      case (k)
        0: begin
          p = pc + 16'h0001;
          `CHK("stack", {p[7:0], p[15:8], x, acc, fl}, {m(0), m(1), m(2), m(3), m(4)})
          fl = fl | 8'h08;
          sp = sp - 16'h0005;
          pc = VEC;
          `CHK("pc", pc, pc_o)
        end
        1: fl = acc | `CXD_FLAGS_FIX;
        2: x = acc;
        3: acc = fl;
        4: acc = x;
        5: {h, x} = sp + 16'h0001;
        6: sp = {h, x} - 16'h0001;
        default: fl = (fl & 8'h79) | {5'h00, v[7], v == 8'h00, 1'b0};
      endcase
      cmp;
    end
  endtask
  // Reset, every opcode once, random stream, then wait and wake
  initial begin
    repeat (12) @(posedge clock_i);
    #1 rstn_i = 1;
    cmp;
    for (i = 0; i < 13; i++) run(i);
    repeat (80) run(rnd() % 13);
    tick;
    op_i = `CXD_OP_WAIT;
    op_valid_i = 1;
    tick;
    op_valid_i = 0;
    repeat (4) tick;
    `CHK("halted", 1'b1, halted_o)
    `CHK("mask", 1'b0, flags_o[`CXD_F_I])
    fl = fl & 8'hf7;
    irq_i = 1;
    await(1);
    irq_i = 0;
    repeat (2) tick;
    await(0);
    p = pc + 16'h0001;
    `CHK("wake stack", {p[7:0], p[15:8], x, acc, fl}, {m(0), m(1), m(2), m(3), m(4)})
    fl = fl | 8'h08;
    sp = sp - 16'h0005;
    pc = VEC;
    `CHK("pc", VEC, pc_o)
    cmp;
    run(0);
    // Mid-run reset, then a prefixed byte outside this slice must be ignored
    rstn_i = 0;
    tick;
    rstn_i = 1;
    acc = 8'h00;
    x = 8'h00;
    h = 8'h00;
    fl = `CXD_FLAGS_RST;
    sp = `CXD_SP_RST;
    pc = 16'h0000;
    cmp;
    `CHK("pc", pc, pc_o)
    `CHK("halted", 1'b0, halted_o)
    op_i = `CXD_OP_PREFIX;
    op2_i = 8'h00;
    op_valid_i = 1;
    tick;
    op_valid_i = 0;
    op2_i = `CXD_OP_TST_SP1;
    `CHK("ignored", 1'b1, op_ready_o)
    cmp;
    run(1);
    end_sim;
  end
endmodule // test_cpu_transfer_test_swi_wait_exec
